// File: rtl/sock_ctrl.sv
/*
 Socket controller: 16-bit card strobes, card status inputs, socket clock,
 clock-run and CardBus reset.
 Assumes card pins arrive asynchronously and a card kind from detection.
*/
// How it works
// R1: Output enable low during memory reads.
// R2: Ready/busy monitored only for memory-only cards.
// R3: Card holds ready/busy low while busy.
// R4: Card drives ready/busy high when ready.
// R5: In I/O mode the line is an active-low interrupt.
// R6: Attribute select high for common memory accesses.
// R7: Attribute select routes to attribute or I/O space.
// R8: Card reset output hard-resets a 16-bit card.
// R9: Voltage decided from both sense lines together.
// R10: Wait held active stretches the cycle.
// R11: Write enable pulsed for memory writes.
// R12: Write-protect reported for memory cards.
// R13: Write-protect read as wide port ack for I/O cards.
// R14: Card asserts wide port ack only for its 16-bit ports.
// R15: CardBus signals sampled on rising socket clock.
// R16: Socket clock at bus rate, slowed or stopped low.
// R17: Clock-run two-way: card asks speed up, device warns.
// R18: Device drives valid levels while CardBus reset held.
// R19: Reset asserts anytime, releases synchronously to socket clock.
// R20: I/O read and write strobes for I/O cycles.
// R21: Even and odd byte selects, active low.
// R22: Pin meanings follow detected card kind.
// R23: Card inputs synchronised before use.
`include "sock_params.svh"
`timescale 1ns/10ps
`default_nettype none
module sock_ctrl (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic CLK_SOCK_SRC,
    input wire sock_pkg::card_kind_t CARD_KIND,
    input wire logic REQ_VALID,
    input wire sock_pkg::req_t REQ,
    output logic REQ_READY,
    output logic REQ_DONE,
    input wire logic CARD_RESET_REQ,
    input wire logic CLK_SLOW_REQ,
    input wire logic CLK_STOP_REQ,
    input wire logic READY_IRQ_PIN,
    input wire logic WAIT_N_PIN,
    input wire logic WP_PIN,
    input wire logic VOLT_SENSE_A,
    input wire logic VOLT_SENSE_B,
    input wire logic SOCKET_CLK_RUN_N_IN,
    output logic SOCKET_CLK_RUN_N_OUT,
    output logic SOCKET_CLK_RUN_N_OE,
    output sock_pkg::strobe_t STROBES,
    output logic CARD_RESET,
    output logic SOCKET_BUS_RESET_N,
    output logic SOCKET_CLK,
    output logic CARD_READY,
    output logic CARD_IRQ,
    output logic WRITE_PROTECT,
    output logic WIDE_PORT,
    output sock_pkg::volt_t VOLTAGE,
    output logic CLK_FAST_WANTED
);
    typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_WAIT} cyc_state_t;
    localparam logic [7:0] STROBE_CYC = 8'(`STROBE_CYC);

    function automatic sock_pkg::volt_t volt_decode(input logic a,
                                                    input logic b);
        case ({a, b})
            2'h3: volt_decode = sock_pkg::VOLT_5V;
            2'h2: volt_decode = sock_pkg::VOLT_3V;
            2'h1: volt_decode = sock_pkg::VOLT_LOW;
            default: volt_decode = sock_pkg::VOLT_NONE;
        endcase
    endfunction

    // R23: two-stage synchronisers
    logic [4:0] s1_q, s2_q;
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            s1_q <= 5'h1f;
            s2_q <= 5'h1f;
        end else begin
            s1_q <= {READY_IRQ_PIN, WAIT_N_PIN, WP_PIN, VOLT_SENSE_A,
                     VOLT_SENSE_B};
            s2_q <= s1_q;
        end
    end
    wire logic rdy_s = s2_q[4];
    wire logic wait_n_s = s2_q[3];
    wire logic wp_s = s2_q[2];
    // R22: pin meaning from card kind
    wire logic mem16 = (CARD_KIND == sock_pkg::CARD_MEM16);
    wire logic io16 = (CARD_KIND == sock_pkg::CARD_IO16);
    wire logic is16 = mem16 || io16;

    // Cycle sequencer
    cyc_state_t st_q, st_d;
    logic [7:0] cnt_q, cnt_d;
    sock_pkg::req_t req_q, req_d;
    sock_pkg::strobe_t stb_q, stb_d;
    logic done_q, done_d;
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        req_d = req_q;
        stb_d = '1;
        done_d = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (REQ_VALID && is16 && !CARD_RESET) begin
                    req_d = REQ;
                    st_d = ST_SETUP;
                end
            end
            ST_SETUP: begin
                cnt_d = STROBE_CYC;
                st_d = ST_STROBE;
            end
            ST_STROBE, ST_WAIT: begin
                // R10: hold off completion while wait low
                if (cnt_q > 8'h1) begin
                    cnt_d = cnt_q - 8'h1;
                end else if (wait_n_s) begin
                    st_d = ST_IDLE;
                    done_d = 1'b1;
                end else begin
                    st_d = ST_WAIT;
                end
            end
            default: st_d = ST_IDLE;
        endcase
        if (st_d != ST_IDLE) begin
            // R6: attribute select high for common memory
            // R7: select asserted for attribute or I/O space
            stb_d.attr_sel_n = !(req_d.attr || req_d.op == sock_pkg::OP_IO_RD
                                 || req_d.op == sock_pkg::OP_IO_WR);
            // R21: even and odd byte selects
            stb_d.even_byte_sel_n = !req_d.byte_en[0];
            stb_d.odd_byte_sel_n = !req_d.byte_en[1];
        end
        if (st_d == ST_STROBE || st_d == ST_WAIT) begin
            // R1: output enable for memory reads
            stb_d.output_en_n = (req_d.op != sock_pkg::OP_MEM_RD);
            // R11: write enable pulse for memory writes
            stb_d.write_en_n = (req_d.op != sock_pkg::OP_MEM_WR);
            // R20: I/O read and write strobes
            stb_d.io_read_strobe_n = (req_d.op != sock_pkg::OP_IO_RD);
            stb_d.io_write_strobe_n = (req_d.op != sock_pkg::OP_IO_WR);
        end
    end
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            st_q <= ST_IDLE;
            cnt_q <= 8'h0;
            req_q <= '0;
            stb_q <= '1;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            req_q <= req_d;
            stb_q <= stb_d;
            done_q <= done_d;
        end
    end
    assign REQ_READY = (st_q == ST_IDLE) && is16 && !CARD_RESET;
    assign REQ_DONE = done_q;
    assign STROBES = stb_q;

    // Status outputs
    logic rdy_q, irq_q, wp_q, wide_q;
    sock_pkg::volt_t volt_q;
    logic rdy_d, irq_d, wp_d, wide_d;
    sock_pkg::volt_t volt_d;
    always_comb begin
        // R2: ready only in memory-only setup
        rdy_d = mem16 && rdy_s;
        // R5: same line is active-low interrupt for I/O cards
        irq_d = io16 && !rdy_s;
        // R12: write-protect switch for memory cards
        wp_d = mem16 && wp_s;
        // R13: wide port ack for I/O cards, active low
        wide_d = io16 && !wp_s;
        // R9: both sense lines decoded together
        volt_d = volt_decode(s2_q[1], s2_q[0]);
    end
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            rdy_q <= 1'b0;
            irq_q <= 1'b0;
            wp_q <= 1'b0;
            wide_q <= 1'b0;
            volt_q <= sock_pkg::VOLT_NONE;
        end else begin
            rdy_q <= rdy_d;
            irq_q <= irq_d;
            wp_q <= wp_d;
            wide_q <= wide_d;
            volt_q <= volt_d;
        end
    end
    assign CARD_READY = rdy_q;
    assign CARD_IRQ = irq_q;
    assign WRITE_PROTECT = wp_q;
    assign WIDE_PORT = wide_q;
    assign VOLTAGE = volt_q;

    // R8: hard reset for 16-bit cards
    logic socket_bus_reset_n_q, socket_bus_reset_n_d;
    always_comb socket_bus_reset_n_d = CARD_RESET_REQ && (CARD_KIND != sock_pkg::CARD_CBUS);
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            socket_bus_reset_n_q <= 1'b1;
        end else begin
            socket_bus_reset_n_q <= socket_bus_reset_n_d;
        end
    end
    assign CARD_RESET = socket_bus_reset_n_q;

    // Socket clock domain
    wire logic cb_rst_req = SYS_RST || (CARD_KIND != sock_pkg::CARD_CBUS)
                            || CARD_RESET_REQ;
    logic cbr1_q, cbr2_q, slow1_q, slow2_q, stop1_q, stop2_q, run1_q, run2_q;
    // R19: asynchronous assert, release on socket clock
    always_ff @(posedge CLK_SOCK_SRC or posedge cb_rst_req) begin
        if (cb_rst_req) begin
            cbr1_q <= 1'b0;
            cbr2_q <= 1'b0;
        end else begin
            cbr1_q <= 1'b1;
            cbr2_q <= cbr1_q;
        end
    end
    // R18: reset output always driven valid
    assign SOCKET_BUS_RESET_N = cbr2_q;

    // R15: clock-run input and slow/stop requests sampled on rising socket clock
    always_ff @(posedge CLK_SOCK_SRC) begin
        slow1_q <= CLK_SLOW_REQ;
        slow2_q <= slow1_q;
        stop1_q <= CLK_STOP_REQ;
        stop2_q <= stop1_q;
        run1_q <= SOCKET_CLK_RUN_N_IN;
        run2_q <= run1_q;
    end

    logic [3:0] div_q, div_d;
    logic gate_q, gate_d, warn_q, warn_d;
    always_comb begin
        div_d = div_q + 4'h1;
        if (div_q == 4'(`SLOW_DIV - 1)) begin
            div_d = 4'h0;
        end
        // R17: card pulling run low before the device warns forces full speed
        // R16: clock gated only while low
        if (!run2_q && !warn_q) begin
            gate_d = 1'b1;
        end else if (stop2_q) begin
            gate_d = 1'b0;
        end else if (slow2_q) begin
            gate_d = (div_q == 4'h0);
        end else begin
            gate_d = 1'b1;
        end
        // R17: warn card of coming reduction
        warn_d = (slow2_q || stop2_q) && (run2_q || warn_q);
    end
    always_ff @(posedge CLK_SOCK_SRC) begin
        if (!cbr2_q) begin
            div_q <= 4'h0;
            gate_q <= 1'b1;
            warn_q <= 1'b0;
        end else begin
            div_q <= div_d;
            gate_q <= gate_d;
            warn_q <= warn_d;
        end
    end
    logic gate_l;
    always_latch begin
        if (!CLK_SOCK_SRC) begin
            gate_l = gate_q;
        end
    end
    assign SOCKET_CLK = CLK_SOCK_SRC && gate_l;
    assign SOCKET_CLK_RUN_N_OUT = 1'b0;
    assign SOCKET_CLK_RUN_N_OE = warn_q;

    logic fw1_q, fw2_q;
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            fw1_q <= 1'b0;
            fw2_q <= 1'b0;
        end else begin
            fw1_q <= !SOCKET_CLK_RUN_N_IN && !SOCKET_CLK_RUN_N_OE;
            fw2_q <= fw1_q;
        end
    end
    assign CLK_FAST_WANTED = fw2_q;

    a_oe_read: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // R1
        !stb_q.output_en_n |-> req_q.op == sock_pkg::OP_MEM_RD)
        else $error("output enable outside memory read");
    a_we_write: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // R11
        !stb_q.write_en_n |-> req_q.op == sock_pkg::OP_MEM_WR)
        else $error("write enable outside memory write");
    a_io_strobes: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // R20
        !(stb_q.io_read_strobe_n && stb_q.io_write_strobe_n) |->
        req_q.op inside {sock_pkg::OP_IO_RD, sock_pkg::OP_IO_WR})
        else $error("io strobe outside io cycle");
    a_attr_common: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // R6
        (st_q != ST_IDLE && !req_q.attr && req_q.op inside
         {sock_pkg::OP_MEM_RD, sock_pkg::OP_MEM_WR}) |-> stb_q.attr_sel_n)
        else $error("attribute select low on common access");
    a_wait_hold: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // R10
        (st_q == ST_WAIT && !wait_n_s) |=> !done_q)
        else $error("cycle ended during wait");
    a_ready_mem: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // R2
        CARD_READY |-> $past(mem16))
        else $error("ready reported for non-memory card");
    a_wide_io: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // R13
        WIDE_PORT |-> $past(io16))
        else $error("wide port outside io card");
    a_byte_sel: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // R21
        (st_q == ST_STROBE) |-> stb_q.even_byte_sel_n == !req_q.byte_en[0])
        else $error("even byte select mismatch");
endmodule
`default_nettype wire

// File: rtl/sock_params.svh
/*
 Socket signalling constants: clock rate, strobe timing, reset hold, slow divider, speed codes.
 Assumes inclusion by bare name from the socket controller and the testbench.
*/
`ifndef SOCK_PARAMS_SVH
`define SOCK_PARAMS_SVH
`define CLK_SYS_MHZ 100
`define STROBE_NS 30
`define STROBE_CYC ((`STROBE_NS * `CLK_SYS_MHZ + 999) / 1000)
`define RST_HOLD_CYC 8
`define SLOW_DIV 4
`define SPEED_OFF 2'h0
`define SPEED_SLOW 2'h1
`define SPEED_FULL 2'h2
`endif

// File: rtl/sock_pkg.sv
/*
 Types shared by the socket controller: card kinds, operations, pin groups.
 Assumes sock_params.svh is available on the include path.
*/
package sock_pkg;
    typedef enum logic [1:0] {CARD_NONE, CARD_MEM16, CARD_IO16, CARD_CBUS}
        card_kind_t;
    typedef enum logic [1:0] {OP_MEM_RD, OP_MEM_WR, OP_IO_RD, OP_IO_WR}
        op_t;
    typedef enum logic [1:0] {VOLT_NONE, VOLT_5V, VOLT_3V, VOLT_LOW}
        volt_t;
    typedef struct packed {
        op_t op;
        logic attr;
        logic [1:0] byte_en;
    } req_t;
    typedef struct packed {
        logic output_en_n;
        logic write_en_n;
        logic io_read_strobe_n;
        logic io_write_strobe_n;
        logic attr_sel_n;
        logic even_byte_sel_n;
        logic odd_byte_sel_n;
    } strobe_t;
endpackage

// File: test/pc_card_socket_signals_tb.sv
/*
 Self-checking bench for the socket controller against a card model.
 Assumes sock_pkg, sock_params.svh and the card model are compiled.
*/
`include "sock_params.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
    $display("[ERR] %0t value mismatch", $time); end end
module pc_card_socket_signals_tb;
    logic clk_sys = 1'b0;
    logic clk_sock = 1'b0;
    logic sys_rst = 1'b1;
    sock_pkg::card_kind_t card_kind;
    sock_pkg::req_t req;
    sock_pkg::req_t r;
    sock_pkg::strobe_t strobes;
    sock_pkg::volt_t volt;
    logic req_valid, req_ready, req_done, card_reset_req, clk_slow_req;
    logic clk_stop_req, run_out, run_oe, card_oe, card_reset, bus_rst_n;
    logic sock_clk, card_ready, card_irq, wprot, wide, fast;
    logic ready_irq, wait_n, wp_pin, vs_a, vs_b;
    logic irq_req, wait_req, wp_sw, wide_req, fast_req;
    logic [1:0] vs;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int k;
    int n;
    wire run_n = ~((run_oe & ~run_out) | card_oe);
    always #5 clk_sys = ~clk_sys;
    initial begin
        #2;
        forever #15 clk_sock = ~clk_sock;
    end
    sock_ctrl i_dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst),
        .CLK_SOCK_SRC(clk_sock), .CARD_KIND(card_kind),
        .REQ_VALID(req_valid), .REQ(req), .REQ_READY(req_ready),
        .REQ_DONE(req_done), .CARD_RESET_REQ(card_reset_req),
        .CLK_SLOW_REQ(clk_slow_req), .CLK_STOP_REQ(clk_stop_req),
        .READY_IRQ_PIN(ready_irq), .WAIT_N_PIN(wait_n), .WP_PIN(wp_pin),
        .VOLT_SENSE_A(vs_a), .VOLT_SENSE_B(vs_b),
        .SOCKET_CLK_RUN_N_IN(run_n), .SOCKET_CLK_RUN_N_OUT(run_out),
        .SOCKET_CLK_RUN_N_OE(run_oe), .STROBES(strobes),
        .CARD_RESET(card_reset), .SOCKET_BUS_RESET_N(bus_rst_n),
        .SOCKET_CLK(sock_clk), .CARD_READY(card_ready),
        .CARD_IRQ(card_irq), .WRITE_PROTECT(wprot), .WIDE_PORT(wide),
        .VOLTAGE(volt), .CLK_FAST_WANTED(fast));
    sock_card_model i_card (.mem_mode(card_kind == sock_pkg::CARD_MEM16),
        .we_n(strobes.write_en_n), .irq_req(irq_req),
        .wait_req(wait_req), .wp_sw(wp_sw), .wide_req(wide_req),
        .vs(vs), .fast_req(fast_req), .ready_irq(ready_irq),
        .wait_n(wait_n), .wp_pin(wp_pin), .vs_a(vs_a), .vs_b(vs_b),
        .clk_run_oe(card_oe));
    task automatic final_report();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end
    function automatic sock_pkg::strobe_t exp_st(sock_pkg::req_t q);
        sock_pkg::strobe_t s;
        s.output_en_n = q.op != sock_pkg::OP_MEM_RD;
        s.write_en_n = q.op != sock_pkg::OP_MEM_WR;
        s.io_read_strobe_n = q.op != sock_pkg::OP_IO_RD;
        s.io_write_strobe_n = q.op != sock_pkg::OP_IO_WR;
        s.attr_sel_n = ~(q.attr || q.op == sock_pkg::OP_IO_RD
            || q.op == sock_pkg::OP_IO_WR);
        s.even_byte_sel_n = ~q.byte_en[0];
        s.odd_byte_sel_n = ~q.byte_en[1];
        return s;
    endfunction
    task automatic run_op(input sock_pkg::req_t q, input int w);
        int i;
        req = q;
        req_valid = 1'b1;
        wait_req = w > 0;
        @(posedge clk_sys);
        for (i = 1; i < 60; i++) begin
            @(negedge clk_sys);
            req_valid = 1'b0;
            if (i == w)
                wait_req = 1'b0;
            if (i == 3 || (w > 0 && i == w - 1))
                `CHK(strobes, exp_st(q))
            if (req_done === 1'b1)
                break;
        end
        if (w == 0)
            `CHK(i, 2 + `STROBE_CYC)
        else
            `CHK(i > w, 1'b1)
        `CHK(strobes, 7'h7f)
    endtask
    initial begin
        {req_valid, card_reset_req, clk_slow_req, clk_stop_req} = 4'h0;
        {irq_req, wait_req, wp_sw, wide_req, fast_req} = 5'h00;
        req = '0;
        vs = 2'h0;
        card_kind = sock_pkg::CARD_MEM16;
        void'($urandom(64412));
        repeat (4) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        for (k = 0; k < 8; k++) begin
            r.op = sock_pkg::op_t'(k % 4);
            r.attr = 1'($urandom % 2);
            r.byte_en = 2'($urandom_range(1, 3));
            card_kind = k < 4 ? sock_pkg::CARD_MEM16 : sock_pkg::CARD_IO16;
            run_op(r, k == 5 ? 12 : 0);
            repeat (k == 1 ? 4 : 0) @(negedge clk_sys);
            if (k == 1)
                `CHK(card_ready, 1'b0)
            repeat (k == 3 ? 20 : 0) @(negedge clk_sys);
            if (k == 3)
                `CHK(card_ready, 1'b1)
        end
        for (k = 0; k < 4; k++) begin
            vs = 2'(k);
            {wide_req, irq_req} = 2'(k);
            wp_sw = k[0];
            card_kind = k < 2 ? sock_pkg::CARD_MEM16 : sock_pkg::CARD_IO16;
            repeat (6) @(negedge clk_sys);
            `CHK(volt, sock_pkg::volt_t'(2'h0 - vs))
            if (k < 2)
                `CHK(wprot, wp_sw)
            else
                `CHK({wide, card_irq}, 2'(k))
        end
        card_reset_req = 1'b1;
        repeat (4) @(negedge clk_sys);
        `CHK({card_reset, req_ready}, 2'h2)
        card_kind = sock_pkg::CARD_CBUS;
        repeat (4) @(negedge clk_sys);
        `CHK({bus_rst_n, req_ready}, 2'h0)
        card_reset_req = 1'b0;
        for (n = 0; n < 200 && bus_rst_n !== 1'b1; n++)
            @(clk_sock or bus_rst_n);
        `CHK(clk_sock, 1'b1)
        clk_slow_req = 1'b1;
        repeat (30) @(negedge clk_sys);
        n = 0;
        repeat (60) @(negedge clk_sys) n += sock_clk;
        `CHK(n > 4 && n < 12, 1'b1)
        clk_slow_req = 1'b0;
        clk_stop_req = 1'b1;
        repeat (30) @(negedge clk_sys);
        n = 0;
        repeat (60) @(negedge clk_sys) n += sock_clk;
        `CHK(n, 0)
        clk_stop_req = 1'b0;
        fast_req = 1'b1;
        repeat (20) @(negedge clk_sys);
        `CHK(fast, 1'b1)
        final_report();
    end
endmodule
`default_nettype wire

// File: test/sock_card_model.sv
/*
 Card model: ready/busy, interrupt, wait, write protect, voltage sense
 and clock-run pull-down.
 Assumes the bench resolves the pulled-up clock-run wire.
*/
`timescale 1ns/10ps
`default_nettype none
module sock_card_model (
    input wire logic mem_mode,
    input wire logic we_n,
    input wire logic irq_req,
    input wire logic wait_req,
    input wire logic wp_sw,
    input wire logic wide_req,
    input wire logic [1:0] vs,
    input wire logic fast_req,
    output logic ready_irq,
    output logic wait_n,
    output logic wp_pin,
    output logic vs_a,
    output logic vs_b,
    output logic clk_run_oe
);
    logic busy = 1'b0;
    always @(negedge we_n) begin
        @(posedge we_n);
        if (mem_mode) begin
            busy = 1'b1;
            #200 busy = 1'b0;
        end
    end
    assign ready_irq = mem_mode ? ~busy : ~irq_req;
    assign wait_n = ~wait_req;
    assign wp_pin = mem_mode ? wp_sw : ~wide_req;
    assign {vs_a, vs_b} = vs;
    assign clk_run_oe = fast_req;
endmodule
`default_nettype wire
